// ### design/sbr_pkg.sv
package sbr_pkg;

  // ****************************************
  // Bus shape
  // ****************************************
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned IDX_W    = 10;
  localparam int unsigned IDX_LSB  = 2;

  // ****************************************
  // Register indices, byte address is four times
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_NODE_ID   = 10'h000;
  localparam logic [IDX_W-1:0] IDX_GAP_CTRL  = 10'h001;
  localparam logic [IDX_W-1:0] IDX_PORT_CAP  = 10'h002;
  localparam logic [IDX_W-1:0] IDX_SPEED_CAP = 10'h003;
  localparam logic [IDX_W-1:0] IDX_LINK_PWR  = 10'h004;

  // ****************************************
  // Field positions, bit 0 of the map is the LSB
  // ****************************************
  localparam int unsigned F_PHYS_ID_LSB = 2;
  localparam int unsigned F_ROOT        = 1;
  localparam int unsigned F_CABLE_PWR   = 0;
  localparam int unsigned F_HOLDOFF     = 7;
  localparam int unsigned F_LONG_REQ    = 6;
  localparam int unsigned F_GAP_LSB     = 0;
  localparam int unsigned F_LINK_CTRL   = 7;
  localparam int unsigned F_CONT        = 6;
  localparam int unsigned F_JIT_LSB     = 3;
  localparam int unsigned F_PWR_LSB     = 0;
  localparam int unsigned F_EXT_LSB     = 5;
  localparam int unsigned F_SPD_LSB     = 5;

  // ****************************************
  // Fixed field values and reset values
  // ****************************************
  localparam logic [2:0] EXT_VAL     = 3'h7;
  localparam logic [4:0] PORT_COUNT  = 5'h02;
  localparam logic [2:0] SPEED_VAL   = 3'h2;
  localparam logic [3:0] DELAY_VAL   = 4'h0;
  localparam logic [2:0] JITTER_VAL  = 3'h0;
  localparam logic [5:0] GAP_RST     = 6'h3f;
  localparam logic       LINK_CTRL_RST = 1'h1;
  localparam logic [1:0] STRAP_WAIT  = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned LONG_RST_US   = 166;
  localparam int unsigned LONG_RST_CYC  = LONG_RST_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RST_CNT_W     = 11;

endpackage : sbr_pkg

// ### design/sbr_regs.sv
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module sbr_regs #(
  parameter int unsigned LONG_RST_CYCLES = sbr_pkg::LONG_RST_CYC
) (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [sbr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [sbr_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [sbr_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Events from the arbitration core
  input  wire logic                       bus_reset_event,
  input  wire logic                       selfid_done,
  input  wire logic [5:0]                 selfid_phys_id,
  input  wire logic                       tree_root_won,
  input  wire logic                       config_gap_load,
  input  wire logic [5:0]                 config_gap_value,
  input  wire logic                       port_busy,
  // Device pins
  input  wire logic                       cable_power_pin,
  input  wire logic                       link_power_status_input,
  input  wire logic                       contender_linkon_pin,
  input  wire logic [2:0]                 power_class_pins,
  // Controls to the arbitration core
  output logic                            root_holdoff,
  output logic                            long_bus_reset_drive,
  output logic [5:0]                      gap_count,
  output logic                            node_id_valid,
  // Self-ID packet fields
  output logic                            selfid_link_active,
  output logic                            selfid_contender,
  output logic [2:0]                      selfid_power_class,
  // Link interface enable
  output logic                            link_if_enable
);
  import sbr_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;
  wire  [5:0] pin_raw;
  wire        cable_pwr_s;
  wire        link_pwr_s;
  wire        cont_s;
  wire  [2:0] pc_s;

  // Pins gathered into one vector
  assign pin_raw = {power_class_pins, contender_linkon_pin,
                    link_power_status_input, cable_power_pin};
  assign cable_pwr_s = pin_sync_q[0];
  assign link_pwr_s  = pin_sync_q[1];
  assign cont_s  = pin_sync_q[2];
  assign pc_s    = pin_sync_q[5:3];

  // Two flops on every pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 6'h00;
      pin_sync_q <= 6'h00;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ****************************************
  // APB decode
  // ****************************************
  wire [IDX_W-1:0] idx;
  wire             aligned;
  wire             hit_node;
  wire             hit_gap;
  wire             hit_port;
  wire             hit_speed;
  wire             hit_link;
  wire             mapped;
  wire             setup_ph;
  wire             acc_done;
  wire             wr_lane0;
  wire             wr_gap;
  wire             wr_link;
  logic            pready_q;

  // Address to register index
  assign idx       = paddr[IDX_LSB +: IDX_W];
  assign aligned   = (paddr[IDX_LSB-1:0] == 2'h0);
  assign hit_node  = aligned && (idx == IDX_NODE_ID);
  assign hit_gap   = aligned && (idx == IDX_GAP_CTRL);
  assign hit_port  = aligned && (idx == IDX_PORT_CAP);
  assign hit_speed = aligned && (idx == IDX_SPEED_CAP);
  assign hit_link  = aligned && (idx == IDX_LINK_PWR);
  assign mapped    = hit_node | hit_gap | hit_port | hit_speed | hit_link;

  // Phases and write strobes
  assign setup_ph  = psel && !penable;
  assign acc_done  = psel && penable && pready_q;
  assign wr_lane0  = acc_done && pwrite && pstrb[0];
  assign wr_gap    = wr_lane0 && hit_gap;
  assign wr_link   = wr_lane0 && hit_link;

  // ****************************************
  // Bus reset sequencing
  // ****************************************
  logic                 long_req_q;
  logic                 drive_q;
  logic [RST_CNT_W-1:0] rst_cnt_q;
  wire                  start_long;
  wire                  any_reset;
  wire                  cnt_last;

  // Long reset waits for idle ports
  assign start_long = long_req_q && !port_busy && !drive_q;
  assign any_reset  = bus_reset_event || start_long;
  assign cnt_last   = (rst_cnt_q == RST_CNT_W'(LONG_RST_CYCLES - 1));

  // Long reset length counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_q   <= 1'b0;
      rst_cnt_q <= '0;
    end else if (start_long) begin
      drive_q   <= 1'b1;
      rst_cnt_q <= '0;
    end else if (drive_q) begin
      drive_q   <= !cnt_last;
      rst_cnt_q <= rst_cnt_q + RST_CNT_W'(1);
    end
  end

  // ****************************************
  // Node identity and root
  // ****************************************
  logic [5:0] phys_id_q;
  logic       id_valid_q;
  logic       root_q;

  // Self-ID result, dropped by bus reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phys_id_q  <= 6'h00;
      id_valid_q <= 1'b0;
    end else if (selfid_done) begin
      phys_id_q  <= selfid_phys_id;
      id_valid_q <= 1'b1;
    end else if (any_reset) begin
      id_valid_q <= 1'b0;
    end
  end

  // Root flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      root_q <= 1'b0;
    end else if (tree_root_won) begin
      root_q <= 1'b1;
    end else if (any_reset) begin
      root_q <= 1'b0;
    end
  end

  // ****************************************
  // Holdoff and reset request
  // ****************************************
  logic holdoff_q;

  // Holdoff survives bus reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      holdoff_q <= 1'b0;
    end else if (wr_gap) begin
      holdoff_q <= pwdata[F_HOLDOFF];
    end
  end

  // Request dropped by bus reset unless a write sets it in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_req_q <= 1'b0;
    end else if (wr_gap && pwdata[F_LONG_REQ]) begin
      long_req_q <= 1'b1;
    end else if (any_reset) begin
      long_req_q <= 1'b0;
    end else if (wr_gap) begin
      long_req_q <= 1'b0;
    end
  end

  // ****************************************
  // Gap count
  // ****************************************
  logic [5:0] gap_q;
  logic       gap_upd_q;
  logic       reset_seen_q;
  wire        gap_load;
  wire        gap_force;

  // Update sources and forcing condition
  assign gap_load  = wr_gap || config_gap_load;
  assign gap_force = any_reset && reset_seen_q && !gap_upd_q && !gap_load;

  // Gap value, update wins over forcing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= GAP_RST;
    end else if (wr_gap) begin
      gap_q <= pwdata[F_GAP_LSB +: 6];
    end else if (config_gap_load) begin
      gap_q <= config_gap_value;
    end else if (gap_force) begin
      gap_q <= GAP_RST;
    end
  end

  // Tracks updates between bus resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_upd_q    <= 1'b0;
      reset_seen_q <= 1'b0;
    end else if (any_reset) begin
      gap_upd_q    <= gap_load;
      reset_seen_q <= 1'b1;
    end else if (gap_load) begin
      gap_upd_q    <= 1'b1;
    end
  end

  // ****************************************
  // Link, contender and power class
  // ****************************************
  logic       link_ctrl_q;
  logic       cont_q;
  logic [2:0] pwr_q;
  logic [1:0] strap_cnt_q;
  wire        strap_take;

  // Straps sampled once synchronisers settle
  assign strap_take = (strap_cnt_q == STRAP_WAIT);

  // Strap wait counter after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q <= 2'h0;
    end else if (strap_cnt_q <= STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  // Link-active control, kept across bus reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_ctrl_q <= LINK_CTRL_RST;
    end else if (wr_link) begin
      link_ctrl_q <= pwdata[F_LINK_CTRL];
    end
  end

  // Contender and class from pins, then software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_q <= 1'b0;
      pwr_q  <= 3'h0;
    end else if (strap_take) begin
      cont_q <= cont_s;
      pwr_q  <= pc_s;
    end else if (wr_link) begin
      cont_q <= pwdata[F_CONT];
      pwr_q  <= pwdata[F_PWR_LSB +: 3];
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  wire [REG_W-1:0] rd_node;
  wire [REG_W-1:0] rd_gap;
  wire [REG_W-1:0] rd_port;
  wire [REG_W-1:0] rd_speed;
  wire [REG_W-1:0] rd_link;
  wire [REG_W-1:0] rd_sel;

  // Register images
  assign rd_node  = {phys_id_q, root_q, cable_pwr_s};
  assign rd_gap   = {holdoff_q, long_req_q, gap_q};
  assign rd_port  = {EXT_VAL, PORT_COUNT};
  assign rd_speed = {SPEED_VAL, 1'b0, DELAY_VAL};
  assign rd_link  = {link_ctrl_q, cont_q, JITTER_VAL, pwr_q};

  // Read mux, unmapped reads zero
  assign rd_sel = ({REG_W{hit_node}}  & rd_node)
                | ({REG_W{hit_gap}}   & rd_gap)
                | ({REG_W{hit_port}}  & rd_port)
                | ({REG_W{hit_speed}} & rd_speed)
                | ({REG_W{hit_link}}  & rd_link);

  // ****************************************
  // APB answer
  // ****************************************
  logic              pslverr_q;
  logic [DATA_W-1:0] prdata_q;

  // Ready one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph && !mapped;
    end
  end

  // Read data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup_ph) begin
      prdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_sel};
    end
  end

  // ****************************************
  // Status toward the core and the link
  // ****************************************
  logic l_act_q;
  logic lif_q;

  // Registered link indications
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      l_act_q <= 1'b0;
      lif_q   <= 1'b0;
    end else begin
      l_act_q <= link_ctrl_q && link_pwr_s;
      lif_q   <= link_pwr_s;
    end
  end

  // Outputs straight from flops
  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign root_holdoff         = holdoff_q;
  assign long_bus_reset_drive = drive_q;
  assign gap_count            = gap_q;
  assign node_id_valid        = id_valid_q;
  assign selfid_link_active   = l_act_q;
  assign selfid_contender     = cont_q;
  assign selfid_power_class   = pwr_q;
  assign link_if_enable       = lif_q;

endmodule : sbr_regs

// ### sim/sbr_regs_props.sv
`timescale 1ns/100ps
module sbr_regs_props #(
  parameter int unsigned LONG_RST_CYCLES = sbr_pkg::LONG_RST_CYC
) (
  // Clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // Register bus
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [sbr_pkg::ADDR_W-1:0] paddr,
  input wire logic [sbr_pkg::DATA_W-1:0] prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // Core events and pins
  input wire logic                       bus_reset_event,
  input wire logic                       selfid_done,
  input wire logic                       config_gap_load,
  input wire logic [5:0]                 config_gap_value,
  input wire logic                       port_busy,
  input wire logic                       link_power_status_input,
  // Controls
  input wire logic                       long_bus_reset_drive,
  input wire logic [5:0]                 gap_count,
  input wire logic                       node_id_valid,
  input wire logic                       selfid_link_active,
  input wire logic                       link_if_enable
);
  import sbr_pkg::*;
  // ****
  // Length of a self-started long reset
  // ****
  logic [10:0] hi_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_cnt_q <= 11'h000;
    else if (long_bus_reset_drive) hi_cnt_q <= hi_cnt_q + 11'h001;
    else hi_cnt_q <= 11'h000;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // Checks
  // ****
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  rd_upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  unmapped_err_a: assert property (psel && !penable && (paddr[11:2] > 10'h004 || paddr[1:0] != 2'h0)
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  id_clear_a: assert property (bus_reset_event && !selfid_done |=> !node_id_valid)
    else $error("node id valid after bus reset");
  id_valid_a: assert property ($rose(node_id_valid) |-> $past(selfid_done))
    else $error("node id valid without self id end");
  gap_cfg_a: assert property (config_gap_load && !(psel && penable && pwrite && paddr == 12'h004)
    |=> gap_count == $past(config_gap_value)) else $error("gap count not loaded from packet");
  long_idle_a: assert property ($rose(long_bus_reset_drive) |-> !$past(port_busy))
    else $error("long reset started during traffic");
  long_len_a: assert property ($fell(long_bus_reset_drive) |-> hi_cnt_q == LONG_RST_CYCLES)
    else $error("long reset length wrong");
  link_act_a: assert property (!link_power_status_input [*6] |-> !selfid_link_active)
    else $error("link active without link power");
  link_en_a: assert property ($rose(link_power_status_input) |-> ##[1:4] link_if_enable)
    else $error("link interface not enabled");
  // Main scenarios
  long_cov: cover property ($fell(long_bus_reset_drive));
  err_cov: cover property (pready && pslverr);
  cfg_cov: cover property (config_gap_load);
endmodule : sbr_regs_props

bind sbr_regs sbr_regs_props #(.LONG_RST_CYCLES(LONG_RST_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bus_reset_event(bus_reset_event), .selfid_done(selfid_done), .config_gap_load(config_gap_load),
  .config_gap_value(config_gap_value), .port_busy(port_busy), .link_power_status_input(link_power_status_input),
  .long_bus_reset_drive(long_bus_reset_drive), .gap_count(gap_count), .node_id_valid(node_id_valid),
  .selfid_link_active(selfid_link_active), .link_if_enable(link_if_enable)
);

// ### sim/sbr_llc_model.sv
`timescale 1ns/100ps
module sbr_link_model (
  // Clock
  input  wire logic                       pclk,
  // Requests
  output logic                            psel,
  output logic                            penable,
  output logic                            pwrite,
  output logic      [sbr_pkg::ADDR_W-1:0] paddr,
  output logic      [sbr_pkg::DATA_W-1:0] pwdata,
  output logic      [3:0]                 pstrb,
  // Answers
  input  wire logic [sbr_pkg::DATA_W-1:0] prdata,
  input  wire logic                       pready,
  input  wire logic                       pslverr
);
  import sbr_pkg::*;
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
  end
  // One transfer, held until ready is sampled high
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [3:0] s, output logic [DATA_W-1:0] rd_val, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_val = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : sbr_link_model

// ### sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import sbr_pkg::*;
  localparam int unsigned LONG_N = 8;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0]        pstrb;
  logic              bus_reset_event, selfid_done, tree_root_won, config_gap_load, port_busy;
  logic [5:0]        selfid_phys_id, config_gap_value, gap_count;
  logic              cable_power_pin, link_power_status_input, contender_linkon_pin;
  logic [2:0]        power_class_pins, selfid_power_class;
  logic              root_holdoff, long_bus_reset_drive, node_id_valid, selfid_link_active;
  logic              selfid_contender, link_if_enable;
  int                fails = 0, num_checks = 0, cyc = 0, n;
  // Clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  sbr_regs #(.LONG_RST_CYCLES(LONG_N)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_reset_event(bus_reset_event), .selfid_done(selfid_done), .selfid_phys_id(selfid_phys_id),
    .tree_root_won(tree_root_won), .config_gap_load(config_gap_load), .config_gap_value(config_gap_value),
    .port_busy(port_busy), .cable_power_pin(cable_power_pin), .link_power_status_input(link_power_status_input),
    .contender_linkon_pin(contender_linkon_pin), .power_class_pins(power_class_pins),
    .root_holdoff(root_holdoff), .long_bus_reset_drive(long_bus_reset_drive), .gap_count(gap_count),
    .node_id_valid(node_id_valid), .selfid_link_active(selfid_link_active),
    .selfid_contender(selfid_contender), .selfid_power_class(selfid_power_class), .link_if_enable(link_if_enable)
  );
  sbr_link_model u_link (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    u_link.xfer(1'b0, a, 32'h0, 4'hf, rd, err);
    chk("register read", rd, exp);
  endtask : rd_reg
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    u_link.xfer(1'b1, a, {24'h0, d}, 4'hf, rd, err);
  endtask : wr
  // Core event pulse, one cycle
  task automatic ev(input logic [3:0] m);
    {bus_reset_event, selfid_done, tree_root_won, config_gap_load} <= m;
    @(posedge pclk);
    {bus_reset_event, selfid_done, tree_root_won, config_gap_load} <= 4'h0;
  endtask : ev
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick
  task automatic hw_reset();
    presetn <= 1'b0;
    tick(4);
    presetn <= 1'b1;
    tick(4);
  endtask : hw_reset
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    presetn = 1'b0;
    {bus_reset_event, selfid_done, tree_root_won, config_gap_load, port_busy} = 5'h00;
    {selfid_phys_id, config_gap_value} = 12'h000;
    {cable_power_pin, link_power_status_input, contender_linkon_pin, power_class_pins} = 6'h3d;
    tick(4);
    presetn <= 1'b1;
    tick(4);
    rd_reg(12'h000, 32'h01);
    rd_reg(12'h004, {24'h0, 2'b00, GAP_RST});
    rd_reg(12'h008, {24'h0, EXT_VAL, PORT_COUNT});
    rd_reg(12'h00c, {24'h0, SPEED_VAL, 1'b0, DELAY_VAL});
    rd_reg(12'h010, {24'h0, LINK_CTRL_RST, 1'b1, JITTER_VAL, 3'h5});
    chk("self id", {27'h0, selfid_link_active, selfid_contender, selfid_power_class}, 32'h1d);
    wr(12'h000, 8'hff);
    wr(12'h008, 8'h00);
    wr(12'h00c, 8'hff);
    wr(12'h004, 8'h95);
    wr(12'h010, 8'h3a);
    rd_reg(12'h000, 32'h01);
    rd_reg(12'h008, {24'h0, EXT_VAL, PORT_COUNT});
    rd_reg(12'h00c, {24'h0, SPEED_VAL, 1'b0, DELAY_VAL});
    rd_reg(12'h004, 32'h95);
    chk("holdoff out", {31'h0, root_holdoff}, 32'h1);
    u_link.xfer(1'b1, 12'h004, 32'h40, 4'he, rd, err);
    rd_reg(12'h004, 32'h95);
    rd_reg(12'h010, 32'h02);
    tick(4);
    chk("link active", {30'h0, selfid_link_active, link_if_enable}, 32'h1);
    u_link.xfer(1'b1, 12'h014, 32'hff, 4'hf, rd, err);
    chk("unmapped write", {31'h0, err}, 32'h1);
    u_link.xfer(1'b0, 12'h005, 32'h0, 4'hf, rd, err);
    chk("misaligned read", {err, rd[30:0]}, 32'h80000000);
    selfid_phys_id <= 6'h2a;
    ev(4'h6);
    rd_reg(12'h000, {24'h0, 6'h2a, 2'b11});
    chk("id valid", {31'h0, node_id_valid}, 32'h1);
    ev(4'h8);
    u_link.xfer(1'b0, 12'h000, 32'h0, 4'hf, rd, err);
    chk("root", {31'h0, rd[1]}, 32'h0);
    chk("id dropped", {31'h0, node_id_valid}, 32'h0);
    rd_reg(12'h004, 32'h95);
    ev(4'h8);
    rd_reg(12'h004, {24'h0, 2'b10, GAP_RST});
    rd_reg(12'h010, 32'h02);
    config_gap_value <= 6'h0a;
    ev(4'h1);
    rd_reg(12'h004, 32'h8a);
    chk("gap out", {26'h0, gap_count}, 32'h0a);
    port_busy <= 1'b1;
    wr(12'h004, 8'hca);
    tick(6);
    chk("long reset held", {31'h0, long_bus_reset_drive}, 32'h0);
    port_busy <= 1'b0;
    while (long_bus_reset_drive !== 1'b1) @(posedge pclk);
    n = 0;
    while (long_bus_reset_drive === 1'b1) begin
      n++;
      @(posedge pclk);
    end
    chk("long reset cycles", n, LONG_N);
    rd_reg(12'h004, 32'h8a);
    cable_power_pin <= 1'b0;
    link_power_status_input <= 1'b0;
    tick(8);
    chk("link if off", {31'h0, link_if_enable}, 32'h0);
    u_link.xfer(1'b0, 12'h000, 32'h0, 4'hf, rd, err);
    chk("cable power", {31'h0, rd[0]}, 32'h0);
    link_power_status_input <= 1'b1;
    wr(12'h010, 8'h80);
    tick(6);
    chk("link active on", {31'h0, selfid_link_active}, 32'h1);
    contender_linkon_pin <= 1'b0;
    power_class_pins <= 3'h3;
    hw_reset();
    rd_reg(12'h010, {24'h0, LINK_CTRL_RST, 1'b0, JITTER_VAL, 3'h3});
    rd_reg(12'h004, {24'h0, 2'b00, GAP_RST});
    chk("holdoff cleared", {31'h0, root_holdoff}, 32'h0);
    print_verdict();
  end
endmodule : tb_top
